// >>> sheet_exit_pkg.sv
// shared constants, types and helpers for the sheet exit sequencer
// assumes a single 40 MHz clock domain (mclk) and no software-visible registers
`default_nettype none

package sheet_exit_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB_TIME_NS   = 1000;
  localparam int DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_W         = 6;
  localparam int TMR_W         = 16;
  localparam int CNT_W         = 8;

  // sensor vector positions
  localparam int NSENS      = 5;
  localparam int SNS_MID    = 0;
  localparam int SNS_ENT    = 1;
  localparam int SNS_PADDLE = 2;
  localparam int SNS_TOP    = 3;
  localparam int SNS_PUNCH  = 4;

  // group sizes for collected stacks
  localparam logic [CNT_W-1:0] GROUP_MAX  = 8'h03;
  localparam logic [CNT_W-1:0] GROUP_LAST = 8'h04;
  localparam logic [CNT_W-1:0] GROUP_REM  = 8'h01;

  // values after reset
  localparam logic RST_OFFSET_FRONT = 1'b1;
  localparam logic RST_LEVER_EXTEND = 1'b1;

  typedef enum logic [1:0] {
    SPD_STOP = 2'b00,
    SPD_EXIT = 2'b01,
    SPD_COPY = 2'b10
  } speed_t;

  typedef enum logic [1:0] {
    MODE_SIMPLE = 2'b00,
    MODE_OFFSET = 2'b01,
    MODE_STAPLE = 2'b10
  } exit_mode_t;

  typedef enum logic [1:0] {
    PLATE_HOME    = 2'b00,
    PLATE_RECEIVE = 2'b01,
    PLATE_SQUARE  = 2'b10,
    PLATE_OUT     = 2'b11
  } plate_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_RECEIVE   = 4'b0001,
    ST_SETPOS    = 4'b0010,
    ST_PLATE     = 4'b0011,
    ST_PASS      = 4'b0100,
    ST_TAIL      = 4'b0101,
    ST_SHIFT_DLY = 4'b0110,
    ST_SHIFT     = 4'b0111,
    ST_ALIGN     = 4'b1000,
    ST_GROUP_OUT = 4'b1001,
    ST_NIP_OUT   = 4'b1010,
    ST_RAISE_DLY = 4'b1011,
    ST_PADDLE    = 4'b1100,
    ST_TRAY      = 4'b1101
  } seq_state_t;

  // sheets in the next stack: three, the remainder, or four to avoid a lone last sheet
  function automatic logic [CNT_W-1:0] group_size(input logic [CNT_W-1:0] total,
                                                  input logic [CNT_W-1:0] left);
    logic [CNT_W-1:0] rem;
    rem = total % GROUP_MAX;
    if (left == GROUP_LAST && rem == GROUP_REM)
      group_size = GROUP_LAST;
    else if (left < GROUP_MAX)
      group_size = left;
    else
      group_size = GROUP_MAX;
  endfunction

endpackage

`default_nettype wire

// >>> sense_filter.sv
// two-stage synchroniser plus debounce for each sensor input
// assumes raw inputs are asynchronous pins; clean outputs are on mclk
`default_nettype none

module sense_filter (
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic [sheet_exit_pkg::NSENS-1:0] raw,
  output var  logic [sheet_exit_pkg::NSENS-1:0] clean
);
  import sheet_exit_pkg::*;

  logic [NSENS-1:0] meta_reg;
  logic [NSENS-1:0] sync_reg;
  logic [DEB_W-1:0] cnt_reg [NSENS];

  // first stage feeds only the second stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  // a level must hold steady for the full debounce time before it is believed
  for (genvar i = 0; i < NSENS; i++) begin : g_deb
    wire logic differs = sync_reg[i] != clean[i];
    wire logic settled = cnt_reg[i] == DEB_W'(DEB_CYCLES - 1);
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        cnt_reg[i] <= '0;
        clean[i]   <= 1'b0;
      end else if (!differs) begin
        cnt_reg[i] <= '0;
      end else if (settled) begin
        cnt_reg[i] <= '0;
        clean[i]   <= sync_reg[i];
      end else begin
        cnt_reg[i] <= cnt_reg[i] + DEB_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// >>> step_timer.sv
// one-shot down counter used for set positions and set delays
// assumes start and load come from logic on mclk
`default_nettype none

module step_timer (
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic                            start,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] load,
  output var  logic                            done
);
  import sheet_exit_pkg::*;

  logic [TMR_W-1:0] cnt_reg;
  logic             run_reg;

  // a load of zero still takes one cycle; a new start restarts the count
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= load;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= TMR_W'(1)) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - TMR_W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> sheet_exit_sequencer.sv
// sequencer that carries sheets onto the movable output tray
// assumes host commands and config inputs are on mclk; sensors are raw pins
`default_nettype none

module sheet_exit_sequencer (
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic                            sheet_expected,
  input  wire logic [1:0]                      mode_cmd,
  input  wire logic [sheet_exit_pkg::CNT_W-1:0] job_count,
  input  wire logic                            host_exit_clear,
  input  wire logic                            punch_fitted,
  input  wire logic                            punch_start,
  input  wire logic                            mid_path_paper_sensor,
  input  wire logic                            entrance_path_sensor,
  input  wire logic                            paddle_home_sensor,
  input  wire logic                            stack_top_sensor,
  input  wire logic                            punch_stop_timing_sensor,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_set_pos,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_plate_time,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_tail_roller,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_tail_knurl,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_raise_delay,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_align_time,
  input  wire logic [sheet_exit_pkg::TMR_W-1:0] cfg_stack_exit,
  input  wire logic [sheet_exit_pkg::CNT_W-1:0] cfg_punch_pulses,
  output var  logic [1:0]                      entrance_feed_motor,
  output var  logic [1:0]                      middle_feed_motor,
  output var  logic [1:0]                      exit_roller_motor,
  output var  logic                            exit_roller_reverse,
  output var  logic                            roller_lower,
  output var  logic [1:0]                      plate_pos,
  output var  logic                            offset_shift,
  output var  logic                            offset_front,
  output var  logic                            paddle_run,
  output var  logic                            lever_extend,
  output var  logic                            tray_down,
  output var  logic                            punch_motor_run,
  output var  logic                            busy
);
  import sheet_exit_pkg::*;

  logic [NSENS-1:0] sens;
  logic [NSENS-1:0] sens_prev_reg;
  seq_state_t       state_reg, state_next;
  exit_mode_t       mode_reg, mode_next;
  logic [CNT_W-1:0] total_reg, total_next;
  logic [CNT_W-1:0] done_reg, done_next;
  logic [CNT_W-1:0] group_reg, group_next;
  logic [CNT_W-1:0] target_reg, target_next;
  logic [CNT_W-1:0] punch_cnt_reg;
  speed_t           ent_next, mid_next, stk_next;
  plate_t           plate_next;
  logic             rev_next, lower_next, shift_next, front_next;
  logic             paddle_next, lever_next, tray_next;
  logic             scrape_reg, scrape_next;
  logic             paddle_left_reg, paddle_left_next;
  logic             tmr_start;
  logic [TMR_W-1:0] tmr_load;
  logic             tmr_done;

  // sensor inputs are cleaned before any decision below looks at them
  sense_filter u_filter (
    .mclk  (mclk),
    .reset (reset),
    .raw   ({punch_stop_timing_sensor, stack_top_sensor, paddle_home_sensor,
             entrance_path_sensor, mid_path_paper_sensor}),
    .clean (sens)
  );

  // one shared timer: the sequence never needs two delays at once
  step_timer u_timer (
    .mclk  (mclk),
    .reset (reset),
    .start (tmr_start),
    .load  (tmr_load),
    .done  (tmr_done)
  );

  // decoded events and mode selection
  wire logic mid_rise    = sens[SNS_MID] & ~sens_prev_reg[SNS_MID];
  wire logic mid_fall    = ~sens[SNS_MID] & sens_prev_reg[SNS_MID];
  wire logic ent_fall    = ~sens[SNS_ENT] & sens_prev_reg[SNS_ENT];
  wire logic punch_pulse = sens[SNS_PUNCH] & ~sens_prev_reg[SNS_PUNCH];
  wire logic in_flight   = (state_reg == ST_PASS) || (state_reg == ST_TAIL);
  wire logic collect     = mode_reg != MODE_SIMPLE;
  wire logic offset_mode = mode_reg == MODE_OFFSET;
  wire exit_mode_t cmd_mode = (mode_cmd == 2'b01) ? MODE_OFFSET :
                              (mode_cmd == 2'b10) ? MODE_STAPLE : MODE_SIMPLE;
  wire logic [CNT_W-1:0] left_now  = total_reg - done_reg;
  wire logic [CNT_W-1:0] group_inc = group_reg + CNT_W'(1);
  wire logic [CNT_W-1:0] done_sum  = done_reg + group_reg;
  wire logic job_end   = done_sum >= total_reg;
  wire logic punch_hit = punch_cnt_reg + CNT_W'(1) >= cfg_punch_pulses;

  // next-state and output decode
  always_comb begin
    state_next       = state_reg;
    mode_next        = mode_reg;
    total_next       = total_reg;
    done_next        = done_reg;
    group_next       = group_reg;
    target_next      = target_reg;
    ent_next         = speed_t'(entrance_feed_motor);
    mid_next         = speed_t'(middle_feed_motor);
    stk_next         = speed_t'(exit_roller_motor);
    plate_next       = plate_t'(plate_pos);
    rev_next         = exit_roller_reverse;
    lower_next       = roller_lower;
    shift_next       = offset_shift;
    front_next       = offset_front;
    paddle_next      = paddle_run;
    lever_next       = lever_extend;
    tray_next        = tray_down;
    scrape_next      = 1'b0;
    paddle_left_next = paddle_left_reg;
    tmr_start        = 1'b0;
    tmr_load         = '0;

    // speed changes that follow the sheet while it is in the path
    if (in_flight && ent_fall)
      ent_next = SPD_EXIT;
    if (in_flight && host_exit_clear) begin
      mid_next = SPD_EXIT;
      if (collect) begin
        stk_next    = SPD_STOP;
        scrape_next = 1'b1;
      end
    end
    // reverse one cycle after the stop, never straight through
    if (scrape_reg) begin
      stk_next = SPD_COPY;
      rev_next = 1'b1;
    end

    case (state_reg)
      ST_IDLE: begin
        ent_next = SPD_STOP;
        mid_next = SPD_STOP;
        if (sheet_expected) begin
          mode_next = cmd_mode;
          if (done_reg == '0) begin
            total_next  = job_count;
            target_next = group_size(job_count, job_count);
          end
          ent_next   = SPD_EXIT;
          mid_next   = SPD_EXIT;
          state_next = ST_RECEIVE;
        end
      end
      ST_RECEIVE: begin
        if (mid_rise) begin
          tmr_start  = 1'b1;
          tmr_load   = cfg_set_pos;
          state_next = ST_SETPOS;
        end
      end
      ST_SETPOS: begin
        if (tmr_done) begin
          ent_next = SPD_COPY;
          mid_next = SPD_COPY;
          if (collect) begin
            plate_next = PLATE_RECEIVE;
            tmr_start  = 1'b1;
            tmr_load   = cfg_plate_time;
            state_next = ST_PLATE;
          end else begin
            lower_next = 1'b1;
            stk_next   = SPD_COPY;
            rev_next   = 1'b0;
            lever_next = 1'b0;
            state_next = ST_PASS;
          end
        end
      end
      ST_PLATE: begin
        if (tmr_done) begin
          lower_next = 1'b1;
          stk_next   = SPD_COPY;
          rev_next   = 1'b0;
          state_next = ST_PASS;
        end
      end
      ST_PASS: begin
        if (mid_fall) begin
          tmr_start  = 1'b1;
          tmr_load   = collect ? cfg_tail_knurl : cfg_tail_roller;
          state_next = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (tmr_done) begin
          lower_next = 1'b0;
          tmr_start  = 1'b1;
          tmr_load   = cfg_raise_delay;
          state_next = collect ? ST_SHIFT_DLY : ST_RAISE_DLY;
        end
      end
      ST_SHIFT_DLY: begin
        if (tmr_done) begin
          shift_next = offset_mode;
          tmr_start  = 1'b1;
          tmr_load   = cfg_align_time;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tmr_done) begin
          stk_next   = SPD_STOP;
          rev_next   = 1'b0;
          plate_next = PLATE_SQUARE;
          tmr_start  = 1'b1;
          tmr_load   = cfg_align_time;
          state_next = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (tmr_done) begin
          group_next = group_inc;
          if (group_inc >= target_reg) begin
            lower_next = 1'b1;
            plate_next = PLATE_OUT;
            tmr_start  = 1'b1;
            tmr_load   = cfg_plate_time;
            state_next = ST_GROUP_OUT;
          end else begin
            state_next = ST_RECEIVE;
          end
        end
      end
      ST_GROUP_OUT: begin
        if (tmr_done) begin
          stk_next   = SPD_COPY;
          rev_next   = 1'b0;
          tmr_start  = 1'b1;
          tmr_load   = cfg_stack_exit;
          state_next = ST_NIP_OUT;
        end
      end
      ST_NIP_OUT: begin
        if (tmr_done) begin
          lower_next = 1'b0;
          plate_next = PLATE_HOME;
          tmr_start  = 1'b1;
          tmr_load   = cfg_raise_delay;
          state_next = ST_RAISE_DLY;
        end
      end
      ST_RAISE_DLY: begin
        if (tmr_done) begin
          paddle_next      = 1'b1;
          paddle_left_next = 1'b0;
          state_next       = ST_PADDLE;
        end
      end
      ST_PADDLE: begin
        // one rotation: leave home, then come back to it
        if (!sens[SNS_PADDLE])
          paddle_left_next = 1'b1;
        if (paddle_left_reg && sens[SNS_PADDLE]) begin
          paddle_next = 1'b0;
          stk_next    = SPD_STOP;
          lever_next  = 1'b1;
          state_next  = ST_TRAY;
        end
      end
      ST_TRAY: begin
        tray_next = sens[SNS_TOP];
        if (!sens[SNS_TOP]) begin
          tray_next  = 1'b0;
          state_next = ST_IDLE;
          if (collect) begin
            group_next = '0;
            front_next = offset_mode ? ~offset_front : offset_front;
            done_next  = job_end ? '0 : done_sum;
            target_next = group_size(total_reg, total_reg - done_sum);
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer registers; outputs other than punch_motor_run come straight from these flops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg           <= ST_IDLE;
      mode_reg            <= MODE_SIMPLE;
      total_reg           <= '0;
      done_reg            <= '0;
      group_reg           <= '0;
      target_reg          <= '0;
      scrape_reg          <= 1'b0;
      paddle_left_reg     <= 1'b0;
      sens_prev_reg       <= '0;
      entrance_feed_motor <= SPD_STOP;
      middle_feed_motor   <= SPD_STOP;
      exit_roller_motor   <= SPD_STOP;
      exit_roller_reverse <= 1'b0;
      roller_lower        <= 1'b0;
      plate_pos           <= PLATE_HOME;
      offset_shift        <= 1'b0;
      offset_front        <= RST_OFFSET_FRONT;
      paddle_run          <= 1'b0;
      lever_extend        <= RST_LEVER_EXTEND;
      tray_down           <= 1'b0;
      busy                <= 1'b0;
    end else begin
      state_reg           <= state_next;
      mode_reg            <= mode_next;
      total_reg           <= total_next;
      done_reg            <= done_next;
      group_reg           <= group_next;
      target_reg          <= target_next;
      scrape_reg          <= scrape_next;
      paddle_left_reg     <= paddle_left_next;
      sens_prev_reg       <= sens;
      entrance_feed_motor <= ent_next;
      middle_feed_motor   <= mid_next;
      exit_roller_motor   <= stk_next;
      exit_roller_reverse <= rev_next;
      roller_lower        <= lower_next;
      plate_pos           <= plate_next;
      offset_shift        <= shift_next;
      offset_front        <= front_next;
      paddle_run          <= paddle_next;
      lever_extend        <= lever_next;
      tray_down           <= tray_next;
      busy                <= state_next != ST_IDLE;
    end
  end

  // punch motor: count timing pulses and stop on the programmed one
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      punch_motor_run <= 1'b0;
      punch_cnt_reg   <= '0;
    end else if (punch_start && punch_fitted && !punch_motor_run) begin
      punch_motor_run <= 1'b1;
      punch_cnt_reg   <= '0;
    end else if (punch_motor_run && punch_pulse) begin
      punch_cnt_reg <= punch_cnt_reg + CNT_W'(1);
      if (punch_hit)
        punch_motor_run <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> sheet_exit_checker.sv
// port assertions for the sheet exit sequencer
// assumes one clock domain on mclk with async high reset
`default_nettype none

module sheet_exit_checker
  import sheet_exit_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       sheet_expected,
  input wire logic       busy,
  input wire logic       punch_start,
  input wire logic       punch_fitted,
  input wire logic       punch_motor_run,
  input wire logic [1:0] entrance_feed_motor,
  input wire logic [1:0] middle_feed_motor,
  input wire logic [1:0] exit_roller_motor,
  input wire logic       exit_roller_reverse,
  input wire logic       roller_lower,
  input wire logic [1:0] plate_pos,
  input wire logic       offset_shift,
  input wire logic       offset_front,
  input wire logic       paddle_run,
  input wire logic       lever_extend,
  input wire logic       tray_down
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // request and feed speed changes
  sheet_start_a: assert property (!busy && sheet_expected |=> busy && entrance_feed_motor == SPD_EXIT)
    else $error("feed motor not started");
  copy_pair_a: assert property (middle_feed_motor == SPD_COPY && $past(middle_feed_motor) != SPD_COPY
    |-> entrance_feed_motor == SPD_COPY) else $error("feed motors not switched together");
  nip_turn_a: assert property ($rose(roller_lower) && plate_pos != PLATE_OUT
    |-> exit_roller_motor == SPD_COPY && !exit_roller_reverse) else $error("roller lowered not turning out");
  // scraping follows exactly one stopped cycle
  stop_rev_a: assert property ($rose(exit_roller_reverse) |-> $past(exit_roller_motor) == SPD_STOP
    && exit_roller_motor == SPD_COPY && middle_feed_motor == SPD_EXIT) else $error("reverse without stop");
  // the roller only lifts off a collected sheet once scraping has begun
  knurl_raise_a: assert property ($fell(roller_lower) && plate_pos == PLATE_RECEIVE
    |-> exit_roller_reverse) else $error("roller raised before scraping");
  paddle_raise_a: assert property ($rose(paddle_run) |-> !roller_lower)
    else $error("paddle with roller down");
  paddle_end_a: assert property ($fell(paddle_run) |-> lever_extend && exit_roller_motor == SPD_STOP)
    else $error("stack motor or lever wrong after paddle");
  tray_lever_a: assert property (tray_down |-> lever_extend)
    else $error("tray moved with lever stored");
  shift_held_a: assert property ($rose(offset_shift) |-> !roller_lower && plate_pos == PLATE_RECEIVE)
    else $error("shift at wrong moment");
  square_stop_a: assert property (plate_pos == PLATE_SQUARE && $past(plate_pos) == PLATE_RECEIVE
    |-> exit_roller_motor == SPD_STOP) else $error("squaring with motor running");
  group_out_a: assert property (plate_pos == PLATE_OUT && $past(plate_pos) != PLATE_OUT |-> roller_lower)
    else $error("plate out without roller down");
  // a finished stack is driven out forwards while still clamped
  nip_exit_a: assert property ($rose(exit_roller_motor == SPD_COPY) && plate_pos == PLATE_OUT
    |-> roller_lower && !exit_roller_reverse) else $error("stack exit without clamp");
  toggle_idle_a: assert property ($changed(offset_front) |-> !paddle_run && lever_extend)
    else $error("offset toggled mid stack");
  punch_go_a: assert property ($rose(punch_motor_run) |-> $past(punch_start) && $past(punch_fitted))
    else $error("punch ran unasked");

  cover property ($rose(exit_roller_reverse));
  cover property ($rose(offset_shift));
  cover property ($fell(paddle_run));
  cover property ($fell(punch_motor_run));
endmodule

bind sheet_exit_sequencer sheet_exit_checker chk (.mclk, .reset, .sheet_expected, .busy, .punch_start,
  .punch_fitted, .punch_motor_run, .entrance_feed_motor, .middle_feed_motor, .exit_roller_motor,
  .exit_roller_reverse, .roller_lower, .plate_pos, .offset_shift, .offset_front, .paddle_run,
  .lever_extend, .tray_down);

`default_nettype wire

// >>> sheet_path_model.sv
// paper path and host exit roller seen by the sequencer
// assumes feed pulses spaced wider than one collect cycle
`default_nettype none

module sheet_path_model (
  input  wire logic mclk,
  input  wire logic feed,
  input  wire logic paddle_run,
  output var  logic mid_path_paper_sensor,
  output var  logic entrance_path_sensor,
  output var  logic host_exit_clear,
  output var  logic paddle_home_sensor,
  output var  logic stack_top_sensor
);
  timeunit 1ns;
  timeprecision 100ps;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // one sheet: tail clears entrance, then host roller, then mid path
  initial begin
    {mid_path_paper_sensor, entrance_path_sensor, host_exit_clear} = 3'h0;
    forever begin
      @(posedge feed);
      {entrance_path_sensor, mid_path_paper_sensor} = 2'h3;
      tick(100);
      entrance_path_sensor = 1'b0;
      tick(20);
      host_exit_clear = 1'b1;
      tick(1);
      host_exit_clear = 1'b0;
      tick(20);
      mid_path_paper_sensor = 1'b0;
    end
  end

  // paddle leaves home longer than debounce; stack top shows so the tray steps
  initial begin
    {paddle_home_sensor, stack_top_sensor} = 2'h2;
    forever begin
      @(posedge paddle_run);
      tick(1);
      paddle_home_sensor = 1'b0;
      tick(39);
      stack_top_sensor = 1'b1;
      tick(11);
      paddle_home_sensor = 1'b1;
      tick(69);
      stack_top_sensor = 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> test_sheet_exit_sequencer.sv
// self-checking bench for the sheet exit sequencer
// assumes the checker and path model are compiled alongside
`default_nettype none

module test_sheet_exit_sequencer import sheet_exit_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 0, reset = 1, sheet_expected = 0, feed = 0, punch_fitted = 0, punch_start = 0;
  logic        punch_stop_timing_sensor = 0, saw_rev = 0, saw_tray = 0;
  logic [1:0]  mode_cmd = 2'h0;
  logic [7:0]  job_count = 8'h01, cfg_punch_pulses = 8'h02;
  logic [15:0] cfg_set_pos = 16'h000A, cfg_plate_time = 16'h000A, cfg_tail_roller = 16'h000A;
  logic [15:0] cfg_tail_knurl = 16'h000A, cfg_raise_delay = 16'h000A, cfg_align_time = 16'h000A;
  logic [15:0] cfg_stack_exit = 16'h0014;
  logic [1:0]  entrance_feed_motor, middle_feed_motor, exit_roller_motor, plate_pos;
  logic        exit_roller_reverse, roller_lower, offset_shift, offset_front, paddle_run;
  logic        lever_extend, tray_down, punch_motor_run, busy, host_exit_clear;
  logic        mid_path_paper_sensor, entrance_path_sensor, paddle_home_sensor, stack_top_sensor;
  logic [3:0]  seen = 4'h0;
  int          failures = 0, n_compared = 0, paddles = 0;

  sheet_exit_sequencer DUT (.mclk, .reset, .sheet_expected, .mode_cmd, .job_count, .host_exit_clear,
    .punch_fitted, .punch_start, .mid_path_paper_sensor, .entrance_path_sensor, .paddle_home_sensor,
    .stack_top_sensor, .punch_stop_timing_sensor, .cfg_set_pos, .cfg_plate_time, .cfg_tail_roller,
    .cfg_tail_knurl, .cfg_raise_delay, .cfg_align_time, .cfg_stack_exit, .cfg_punch_pulses,
    .entrance_feed_motor, .middle_feed_motor, .exit_roller_motor, .exit_roller_reverse, .roller_lower,
    .plate_pos, .offset_shift, .offset_front, .paddle_run, .lever_extend, .tray_down, .punch_motor_run, .busy);
  sheet_path_model path (.mclk, .feed, .paddle_run, .mid_path_paper_sensor, .entrance_path_sensor,
    .host_exit_clear, .paddle_home_sensor, .stack_top_sensor);

  initial forever #12.5 mclk = ~mclk;

  // event monitors for things too brief to poll
  always @(posedge paddle_run) paddles++;
  always @(posedge exit_roller_reverse) saw_rev = 1'b1;
  always @(posedge tray_down) saw_tray = 1'b1;
  always @(plate_pos) seen[plate_pos] = 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic t_simple;
    mode_cmd = MODE_SIMPLE;
    {sheet_expected, feed} = 2'h3;
    tick(1);
    {sheet_expected, feed} = 2'h0;
    check({entrance_feed_motor, middle_feed_motor}, 8'h05);
    repeat (400) if (middle_feed_motor !== SPD_COPY) tick(1);
    check({entrance_feed_motor, exit_roller_motor, roller_lower, lever_extend}, 8'h2A);
    repeat (400) if (middle_feed_motor !== SPD_EXIT) tick(1);
    check({middle_feed_motor, entrance_feed_motor}, 8'h06);
    repeat (400) if (entrance_feed_motor !== SPD_EXIT) tick(1);
    check({entrance_feed_motor, middle_feed_motor}, 8'h05);
    repeat (400) if (roller_lower !== 1'b0) tick(1);
    check(exit_roller_motor, SPD_COPY);
    repeat (400) if (paddle_run !== 1'b1) tick(1);
    check(roller_lower, 1'b0);
    repeat (400) if (paddle_run !== 1'b0) tick(1);
    check({exit_roller_motor, lever_extend}, 8'h01);
    repeat (400) if (busy !== 1'b0) tick(1);
    check({busy, saw_tray}, 8'h01);
  endtask

  // a whole collected job; the stack leaves only after the last sheet
  task automatic t_collect(input logic [1:0] mode, input logic [7:0] n);
    logic front;
    front = offset_front;
    paddles = 0;
    mode_cmd = mode;
    job_count = n;
    sheet_expected = 1'b1;
    repeat (n) begin
      check(paddles[7:0], 8'h00);
      feed = 1'b1;
      tick(1);
      {sheet_expected, feed} = 2'h0;
      tick(299);
    end
    repeat (800) if (busy !== 1'b0) tick(1);
    check({busy, paddles[6:0]}, 8'h01);
    check(offset_front, front ^ (mode == MODE_OFFSET));
  endtask

  task automatic t_punch;
    // a start without the unit fitted must leave the motor still
    punch_start = 1'b1;
    tick(1);
    check(punch_motor_run, 1'b0);
    punch_fitted = 1'b1;
    tick(1);
    punch_start = 1'b0;
    repeat (2) begin
      check(punch_motor_run, 1'b1);
      punch_stop_timing_sensor = 1'b1;
      tick(60);
      punch_stop_timing_sensor = 1'b0;
      tick(60);
    end
    check(punch_motor_run, 1'b0);
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    stop_test;
  end

  initial begin
    tick(4);
    reset = 1'b0;
    check({busy, lever_extend, offset_front, middle_feed_motor}, 8'h0C);
    t_simple;
    t_collect(MODE_OFFSET, 8'h04);
    check(seen, 4'hF);
    check({saw_rev, offset_shift}, 8'h03);
    t_collect(MODE_OFFSET, 8'h02);
    t_collect(MODE_STAPLE, 8'h01);
    t_punch;
    stop_test;
  end
endmodule

`default_nettype wire
